// [design/gpc_pkg.sv]
/*
 pin function configuration package: register map, field positions,
 reset values, timing constants, pin function encodings.
 assumes a 40 MHz system clock and an APB register bus.
*/
package gpc_pkg;
    localparam logic [7:0]  ADDR_CFG       = 8'h88;
    localparam logic [7:0]  ADDR_IRQ_STS   = 8'h8C;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h90;
    localparam logic [7:0]  ADDR_IRQ_EN    = 8'h94;
    localparam int          LED_LSB        = 28;
    localparam int          POL_LSB        = 24;
    localparam int          FUNC_LSB       = 20;
    localparam int          DRV_LSB        = 16;
    localparam int          DIR_LSB        = 8;
    localparam int          GPO_LSB        = 3;
    localparam int          DATA_LSB       = 0;
    localparam logic [31:0] CFG_WMASK      = 32'h7777_071F;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
    localparam logic [2:0]  IRQ_MASK3      = 3'h7;
    localparam int          CLK_MHZ        = 40;
    localparam int          IRQ_MIN_NS     = 40;
    // more than 40 ns: strictly greater, so one cycle beyond the floor
    localparam int          IRQ_MIN_CYC    = (IRQ_MIN_NS * CLK_MHZ) / 1000 + 1;
    localparam int          FILT_W         = 2;
    typedef enum logic [2:0] {
        FN_MEM      = 3'h0,
        FN_GPO      = 3'h1,
        FN_RSV_A    = 3'h2,
        FN_GPO_RXDV = 3'h3,
        FN_RSV_B    = 3'h4,
        FN_TXEN_GPO = 3'h5,
        FN_TXEN_RX  = 3'h6,
        FN_CLKS     = 3'h7
    } gpc_func_e;
endpackage : gpc_pkg

// [design/gpc_level_filter.sv]
/*
 level qualifier for one gpio interrupt input.
 assumes pin input synchronous to clk_i.
*/
`timescale 1ns/1ps
module gpc_level_filter (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic level_i,
    output logic      hit_o
);
    logic [gpc_pkg::FILT_W-1:0] cnt_r;
    logic                       done;

    assign done = (cnt_r == gpc_pkg::FILT_W'(gpc_pkg::IRQ_MIN_CYC));

    always_ff @(posedge clk_i) begin
        if (reset_i || !level_i) begin
            cnt_r <= '0;
            hit_o <= 1'b0;
        end else begin
            if (!done) begin
                cnt_r <= cnt_r + 1'b1;
            end
            hit_o <= done;
        end
    end

    chk_filter_short : assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(hit_o) |-> $past(level_i, 1) && $past(level_i, 2))
        else $error("filter hit after short pulse");
endmodule : gpc_level_filter

// [design/gpc_pin_mux.sv]
/*
 serial-memory pin function multiplexer.
 assumes all sources synchronous to clk_i.
*/
`timescale 1ns/1ps
module gpc_pin_mux (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] func_i,
    input  wire logic       mem_data_i,
    input  wire logic       mem_data_oe_n_i,
    input  wire logic       mem_clk_i,
    input  wire logic       gpo_a_i,
    input  wire logic       gpo_b_i,
    input  wire logic       tx_en_i,
    input  wire logic       rx_dv_i,
    input  wire logic       tx_clk_i,
    input  wire logic       rx_clk_i,
    output logic            data_pin_o,
    output logic            data_pin_oe_n_o,
    output logic            clk_pin_o
);
    logic d_nxt;
    logic c_nxt;
    logic oe_n_nxt;

    always_comb begin
        d_nxt    = 1'b0;
        c_nxt    = 1'b0;
        oe_n_nxt = 1'b0;
        case (func_i)
            gpc_pkg::FN_MEM: begin
                d_nxt    = mem_data_i;
                c_nxt    = mem_clk_i;
                oe_n_nxt = mem_data_oe_n_i;
            end
            gpc_pkg::FN_GPO: begin
                d_nxt = gpo_a_i;
                c_nxt = gpo_b_i;
            end
            gpc_pkg::FN_GPO_RXDV: begin
                d_nxt = gpo_a_i;
                c_nxt = rx_dv_i;
            end
            gpc_pkg::FN_TXEN_GPO: begin
                d_nxt = tx_en_i;
                c_nxt = gpo_b_i;
            end
            gpc_pkg::FN_TXEN_RX: begin
                d_nxt = tx_en_i;
                c_nxt = rx_dv_i;
            end
            gpc_pkg::FN_CLKS: begin
                d_nxt = tx_clk_i;
                c_nxt = rx_clk_i;
            end
            // reserved codes: data pin floats, clock pin low
            default: begin
                oe_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_pin_o      <= 1'b0;
            data_pin_oe_n_o <= 1'b1;
            clk_pin_o       <= 1'b0;
        end else begin
            data_pin_o      <= d_nxt;
            data_pin_oe_n_o <= oe_n_nxt;
            clk_pin_o       <= c_nxt;
        end
    end

    chk_mux_gpo : assert property (@(posedge clk_i) disable iff (reset_i)
        (func_i == gpc_pkg::FN_GPO) |=> (clk_pin_o == $past(gpo_b_i)))
        else $error("general out b not routed");
endmodule : gpc_pin_mux

// [design/gpc_top.sv]
/*
 pin function configuration block: four apb registers, three gpio/led pins,
 two general outputs, serial-memory pin mux, level interrupts.
 assumes one 40 MHz clock, synchronous active high reset, pins
 synchronous to clk_i, and an apb master keeping the protocol.
*/
`timescale 1ns/1ps
module gpc_top (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [2:0]  pin_data_i,
    output logic [2:0]       pin_data_o,
    output logic [2:0]       pin_data_oe_n_o,
    input  wire logic [2:0]  indicator_i,
    input  wire logic        mem_data_i,
    input  wire logic        mem_data_oe_n_i,
    input  wire logic        mem_clk_i,
    output logic             mem_data_o,
    input  wire logic        serial_mem_data_pin_i,
    output logic             serial_mem_data_pin_o,
    output logic             serial_mem_data_pin_oe_n_o,
    output logic             serial_mem_clock_pin_o,
    input  wire logic        tx_en_i,
    input  wire logic        rx_dv_i,
    input  wire logic        tx_clk_i,
    input  wire logic        rx_clk_i,
    output logic [2:0]       pin_irq_o,
    output logic             irq_o
);
    logic [31:0] cfg_r;
    logic [2:0]  sts_r;
    logic [2:0]  mask_r;
    logic [2:0]  pin_irq_enable_r;
    logic [2:0]  hit;
    logic [2:0]  lvl;
    logic [2:0]  ev;
    logic [2:0]  indicator_select;
    logic [2:0]  pin_irq_level_sel;
    logic [2:0]  pin_drive_type;
    logic [2:0]  pin_direction;
    logic [2:0]  pin_data;
    logic [1:0]  general_out_value;
    logic [2:0]  serial_mem_pin_func;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        sel_cfg;
    logic        sel_sts;
    logic        sel_mask;
    logic        sel_en;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [31:0] cfg_live;
    logic [2:0]  sts_nxt;

    assign indicator_select    = cfg_r[gpc_pkg::LED_LSB +: 3];
    assign pin_irq_level_sel   = cfg_r[gpc_pkg::POL_LSB +: 3];
    assign serial_mem_pin_func = cfg_r[gpc_pkg::FUNC_LSB +: 3];
    assign pin_drive_type      = cfg_r[gpc_pkg::DRV_LSB +: 3];
    assign pin_direction       = cfg_r[gpc_pkg::DIR_LSB +: 3];
    assign general_out_value   = cfg_r[gpc_pkg::GPO_LSB +: 2];
    assign pin_data            = cfg_r[gpc_pkg::DATA_LSB +: 3];

    // apb decode, zero wait states
    assign acc      = psel_i && penable_i;
    assign wr       = acc && pwrite_i;
    assign rd       = acc && !pwrite_i;
    assign sel_cfg  = (paddr_i == gpc_pkg::ADDR_CFG);
    assign sel_sts  = (paddr_i == gpc_pkg::ADDR_IRQ_STS);
    assign sel_mask = (paddr_i == gpc_pkg::ADDR_IRQ_MASK);
    assign sel_en   = (paddr_i == gpc_pkg::ADDR_IRQ_EN);
    assign mapped   = sel_cfg || sel_sts || sel_mask || sel_en;

    // live pin state replaces stored data bits on read
    assign cfg_live = {cfg_r[31:3], pin_data_i};
    assign rd_mux   = sel_cfg  ? cfg_live :
                      sel_sts  ? {29'h0, sts_r} :
                      sel_mask ? {29'h0, mask_r} :
                      sel_en   ? {29'h0, pin_irq_enable_r} : 32'h0000_0000;

    // level chosen by polarity on input pins only, filtered event qualified by enable
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            assign lvl[g] = (pin_data_i[g] == pin_irq_level_sel[g])
                            && !pin_direction[g] && !indicator_select[g];
            gpc_level_filter u_filt (
                .clk_i   (clk_i),
                .reset_i (reset_i),
                .level_i (lvl[g]),
                .hit_o   (hit[g])
            );
            assign ev[g] = hit[g] && pin_irq_enable_r[g];
        end
    endgenerate

    // set wins over read-clear
    assign sts_nxt = ((rd && sel_sts) ? 3'h0 : sts_r) | ev;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_r            <= gpc_pkg::CFG_RESET;
            mask_r           <= 3'h0;
            pin_irq_enable_r <= 3'h0;
        end else if (wr) begin
            if (sel_cfg) begin
                cfg_r <= pwdata_i & gpc_pkg::CFG_WMASK;
            end
            if (sel_mask) begin
                mask_r <= pwdata_i[2:0];
            end
            if (sel_en) begin
                pin_irq_enable_r <= pwdata_i[2:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sts_r     <= 3'h0;
            irq_o     <= 1'b0;
            pin_irq_o <= 3'h0;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            sts_r     <= sts_nxt;
            irq_o     <= |(sts_nxt & mask_r);
            pin_irq_o <= ev;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rd_mux : prdata_o;
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
        end
    end

    // pin drivers
    logic [2:0] drv_val;
    logic [2:0] drv_oe_n;
    generate
        for (g = 0; g < 3; g++) begin : g_drv
            always_comb begin
                drv_val[g]  = 1'b0;
                drv_oe_n[g] = 1'b1;
                if (indicator_select[g]) begin
                    drv_val[g]  = indicator_i[g];
                    drv_oe_n[g] = 1'b0;
                end else if (pin_direction[g]) begin
                    drv_val[g]  = pin_data[g];
                    drv_oe_n[g] = !pin_drive_type[g] && pin_data[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_data_o      <= 3'h0;
            pin_data_oe_n_o <= 3'h7;
            mem_data_o      <= 1'b0;
        end else begin
            pin_data_o      <= drv_val;
            pin_data_oe_n_o <= drv_oe_n;
            mem_data_o      <= serial_mem_data_pin_i;
        end
    end

    gpc_pin_mux u_mux (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .func_i          (serial_mem_pin_func),
        .mem_data_i      (mem_data_i),
        .mem_data_oe_n_i (mem_data_oe_n_i),
        .mem_clk_i       (mem_clk_i),
        .gpo_a_i         (general_out_value[0]),
        .gpo_b_i         (general_out_value[1]),
        .tx_en_i         (tx_en_i),
        .rx_dv_i         (rx_dv_i),
        .tx_clk_i        (tx_clk_i),
        .rx_clk_i        (rx_clk_i),
        .data_pin_o      (serial_mem_data_pin_o),
        .data_pin_oe_n_o (serial_mem_data_pin_oe_n_o),
        .clk_pin_o       (serial_mem_clock_pin_o)
    );

    chk_led_drive : assert property (@(posedge clk_i) disable iff (reset_i)
        indicator_select[0] |=> (!pin_data_oe_n_o[0] && pin_data_o[0] == $past(indicator_i[0])))
        else $error("led pin not driven");
    chk_input_float : assert property (@(posedge clk_i) disable iff (reset_i)
        (!indicator_select[1] && !pin_direction[1]) |=> pin_data_oe_n_o[1])
        else $error("input pin driven");
    chk_open_drain : assert property (@(posedge clk_i) disable iff (reset_i)
        (!indicator_select[2] && pin_direction[2] && !pin_drive_type[2] && pin_data[2])
        |=> pin_data_oe_n_o[2])
        else $error("open drain drove high");
    chk_irq_enable : assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(sts_r[0]) |-> $past(pin_irq_enable_r[0]) && $past(hit[0]))
        else $error("status set while disabled");
    chk_irq_polarity : assert property (@(posedge clk_i) disable iff (reset_i)
        hit[0] |-> $past(pin_data_i[0]) == $past(pin_irq_level_sel[0]))
        else $error("wrong level polarity");
    chk_rsv_zero : assert property (@(posedge clk_i) disable iff (reset_i)
        (cfg_r & ~gpc_pkg::CFG_WMASK) == 32'h0000_0000)
        else $error("reserved bit set");
    chk_read_live : assert property (@(posedge clk_i) disable iff (reset_i)
        (psel_i && !penable_i && !pwrite_i && sel_cfg)
        |=> prdata_o[2:0] == $past(pin_data_i))
        else $error("read not live pin state");
    chk_gpo_route : assert property (@(posedge clk_i) disable iff (reset_i)
        (serial_mem_pin_func == gpc_pkg::FN_GPO) && $stable(serial_mem_pin_func)
        |=> serial_mem_data_pin_o == $past(general_out_value[0]))
        else $error("general out a not routed");
    chk_func_reset : assert property (@(posedge clk_i)
        $fell(reset_i) |-> serial_mem_pin_func == gpc_pkg::FN_MEM)
        else $error("function field not reset");

    cov_irq    : cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
    cov_led    : cover property (@(posedge clk_i) disable iff (reset_i) indicator_select[2]);
    cov_clks   : cover property (@(posedge clk_i) disable iff (reset_i)
        serial_mem_pin_func == gpc_pkg::FN_CLKS);
    cov_rdclr  : cover property (@(posedge clk_i) disable iff (reset_i) rd && sel_sts && |sts_r);
endmodule : gpc_top

// [tb/gpc_board_model.sv]
/*
 board around the block: pulled-up gpio lines, an external driver
 per gpio line, and the pulled-up serial-memory data line.
 assumes the block drives a line only while its oe_n is low.
*/
`timescale 1ns/1ps
module gpc_board_model (
    input  wire logic [2:0] drv_val_i,
    input  wire logic [2:0] drv_oe_n_i,
    input  wire logic [2:0] ext_val_i,
    input  wire logic [2:0] ext_en_i,
    input  wire logic       mem_pin_i,
    input  wire logic       mem_pin_oe_n_i,
    output logic [2:0]      pin_o,
    output logic            mem_pin_o
);
    // released lines float to the pull-up level unless the external driver of that gpio line is enabled
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_o[i] = !drv_oe_n_i[i] ? drv_val_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
        end
        mem_pin_o = mem_pin_oe_n_i ? 1'b1 : mem_pin_i;
    end
endmodule : gpc_board_model

// [tb/tb.sv]
/*
 testbench: apb read and write tasks and directed sequences.
 assumes gpc_top, gpc_pkg and the board model are compiled first.
*/
`timescale 1ns/1ps
module tb;
    logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rdata;
    logic        rerr;
    logic [2:0]  pin_data_i, pin_data_o, pin_data_oe_n_o, indicator_i, pin_irq_o;
    logic [2:0]  ext_val_i, ext_en_i;
    logic        mem_data_i, mem_data_oe_n_i, mem_clk_i, mem_data_o, irq_o;
    logic        sm_pin_i, sm_pin_o, sm_pin_oe_n_o, sm_clk_o;
    logic        tx_en_i, rx_dv_i, tx_clk_i, rx_clk_i;
    int          errors, n_tests;
    localparam logic [2:0] CODES [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    // per code: 1 where the pin shows the inverted stimulus level
    localparam logic [7:0] DINV = 8'h8A;
    localparam logic [7:0] CINV = 8'h49;

    gpc_top dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_data_i(pin_data_i),
        .pin_data_o(pin_data_o), .pin_data_oe_n_o(pin_data_oe_n_o), .indicator_i(indicator_i),
        .mem_data_i(mem_data_i), .mem_data_oe_n_i(mem_data_oe_n_i), .mem_clk_i(mem_clk_i),
        .mem_data_o(mem_data_o), .serial_mem_data_pin_i(sm_pin_i),
        .serial_mem_data_pin_o(sm_pin_o), .serial_mem_data_pin_oe_n_o(sm_pin_oe_n_o),
        .serial_mem_clock_pin_o(sm_clk_o), .tx_en_i(tx_en_i), .rx_dv_i(rx_dv_i),
        .tx_clk_i(tx_clk_i), .rx_clk_i(rx_clk_i), .pin_irq_o(pin_irq_o), .irq_o(irq_o));

    gpc_board_model board (.drv_val_i(pin_data_o), .drv_oe_n_i(pin_data_oe_n_o),
        .ext_val_i(ext_val_i), .ext_en_i(ext_en_i), .mem_pin_i(sm_pin_o),
        .mem_pin_oe_n_i(sm_pin_oe_n_o), .pin_o(pin_data_i), .mem_pin_o(sm_pin_i));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rdata = prdata_o;
        rerr  = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rdata);
    endtask : rd_chk

    task settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    // hold gpio0 at lvl for n edges, then return it
    task pulse(input int n, input logic lvl, input logic [2:0] exp_irq);
        @(posedge clk_i);
        ext_val_i[0] <= lvl;
        repeat (n) @(posedge clk_i);
        #1;
        check("pin irq", 32'(exp_irq), 32'(pin_irq_o));
        ext_val_i[0] <= !lvl;
        settle;
    endtask : pulse

    task give_verdict;
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        #(25 * 20000);
        errors++;
        give_verdict;
    end

    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {indicator_i, ext_val_i, ext_en_i, mem_data_i, mem_clk_i} = '0;
        {tx_en_i, rx_dv_i, tx_clk_i, rx_clk_i} = '0;
        mem_data_oe_n_i = 1'b0;
        errors  = 0;
        n_tests = 0;
        reset_i = 1'b1;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        check("oe_n after reset", 32'h7, 32'(pin_data_oe_n_o));
        rd_chk("cfg reset", gpc_pkg::ADDR_CFG, 32'h0000_0007);
        rd_chk("unmapped read", 8'h00, 32'h0000_0000);
        check("unmapped slverr", 32'h1, 32'(rerr));
        wr(gpc_pkg::ADDR_CFG, 32'hFFFF_FFFF);
        rd_chk("cfg reserved", gpc_pkg::ADDR_CFG, 32'h7777_0718);
        check("cfg slverr", 32'h0, 32'(rerr));
        wr(gpc_pkg::ADDR_CFG, 32'h0007_0705);
        settle;
        check("push-pull oe_n", 32'h0, 32'(pin_data_oe_n_o));
        check("output pins", 32'h5, 32'(pin_data_i));
        rd_chk("cfg outputs", gpc_pkg::ADDR_CFG, 32'h0007_0705);
        wr(gpc_pkg::ADDR_CFG, 32'h0000_0702);
        settle;
        check("open-drain oe_n", 32'h2, 32'(pin_data_oe_n_o));
        ext_en_i  <= 3'h7;
        ext_val_i <= 3'h2;
        wr(gpc_pkg::ADDR_CFG, 32'h0000_0000);
        settle;
        check("input oe_n", 32'h7, 32'(pin_data_oe_n_o));
        rd_chk("cfg live pins", gpc_pkg::ADDR_CFG, 32'h0000_0002);
        ext_en_i    <= 3'h0;
        indicator_i <= 3'h6;
        wr(gpc_pkg::ADDR_CFG, 32'h7007_0000);
        settle;
        check("led oe_n", 32'h0, 32'(pin_data_oe_n_o));
        check("led pins", 32'h6, 32'(pin_data_i));
        // memory controller driving, reserved codes skipped
        for (int v = 0; v < 2; v++) begin
            mem_data_i <= v[0];
            mem_clk_i  <= !v[0];
            tx_en_i    <= v[0];
            rx_dv_i    <= !v[0];
            tx_clk_i   <= !v[0];
            rx_clk_i   <= v[0];
            foreach (CODES[k]) begin
                wr(gpc_pkg::ADDR_CFG, {9'h0, CODES[k], 15'h0, v[0], !v[0], 3'h0});
                settle;
                check("data pin", 32'(v[0] ^ DINV[CODES[k]]), 32'(sm_pin_o));
                check("clock pin", 32'(v[0] ^ CINV[CODES[k]]), 32'(sm_clk_o));
                check("mem data in", 32'(v[0] ^ DINV[CODES[k]]), 32'(mem_data_o));
            end
        end
        // controller releases the data line: pull-up level comes back
        mem_data_oe_n_i <= 1'b1;
        wr(gpc_pkg::ADDR_CFG, 32'h0000_0000);
        settle;
        check("mem pin released", 32'h1, 32'(sm_pin_oe_n_o));
        check("mem pull-up in", 32'h1, 32'(mem_data_o));
        mem_data_oe_n_i <= 1'b0;
        ext_en_i  <= 3'h1;
        ext_val_i <= 3'h0;
        wr(gpc_pkg::ADDR_CFG, 32'h0100_0000);
        wr(gpc_pkg::ADDR_IRQ_EN, 32'h0000_0007);
        wr(gpc_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        apb(1'b0, gpc_pkg::ADDR_IRQ_STS, 32'h0000_0000);
        pulse(1, 1'b1, 3'h0);
        rd_chk("short pulse", gpc_pkg::ADDR_IRQ_STS, 32'h0);
        pulse(6, 1'b1, 3'h1);
        check("irq high level", 32'h1, 32'(irq_o));
        rd_chk("sts high level", gpc_pkg::ADDR_IRQ_STS, 32'h1);
        rd_chk("sts cleared", gpc_pkg::ADDR_IRQ_STS, 32'h0);
        #1;
        check("irq cleared", 32'h0, 32'(irq_o));
        @(posedge clk_i);
        ext_val_i[0] <= 1'b1;
        wr(gpc_pkg::ADDR_CFG, 32'h0000_0000);
        apb(1'b0, gpc_pkg::ADDR_IRQ_STS, 32'h0000_0000);
        pulse(6, 1'b0, 3'h1);
        rd_chk("sts low level", gpc_pkg::ADDR_IRQ_STS, 32'h1);
        wr(gpc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        pulse(6, 1'b0, 3'h1);
        check("irq masked", 32'h0, 32'(irq_o));
        rd_chk("sts masked", gpc_pkg::ADDR_IRQ_STS, 32'h1);
        wr(gpc_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        wr(gpc_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        pulse(6, 1'b0, 3'h0);
        rd_chk("sts disabled", gpc_pkg::ADDR_IRQ_STS, 32'h0);
        wr(gpc_pkg::ADDR_IRQ_EN, 32'h0000_0007);
        wr(gpc_pkg::ADDR_CFG, 32'h0000_0100);
        settle;
        rd_chk("sts output pin", gpc_pkg::ADDR_IRQ_STS, 32'h0);
        give_verdict;
    end
endmodule : tb
